/* File: design/stream_align_map.vh */
// register map and timing constants of the stream alignment block
`ifndef STREAM_ALIGN_MAP_VH
`define STREAM_ALIGN_MAP_VH
// register indices; byte address is four times the index
`define IDX_LOCAL_CHAN_DELAY 9'h003
`define IDX_LOCAL_BIT_DELAY 9'h023
`define IDX_BP_CHAN_DELAY 9'h043
`define IDX_BP_BIT_DELAY 9'h063
`define IDX_LOCAL_OUT_ADV 9'h083
`define IDX_BP_OUT_ADV 9'h0a3
`define IDX_CTRL 9'h0c3
`define IDX_LOCAL_RATE 9'h0cd
`define IDX_BP_RATE 9'h10d
`define NUM_STREAMS 32
// control register fields
`define CTRL_FAST_BIT 0
`define CTRL_FRAME_RST_BIT 1
// field widths
`define W_LCD 8
`define W_BCD 9
`define W_BITDLY 5
`define W_ADV 2
`define W_RATE 2
`define FIELD_RESET 16'h0000
// quarter-bit ticks: 4 ticks per bit, 8 bits per channel
`define QTICK_PER_CHAN 6'h20
`define AXI_OKAY 2'b00
`define AXI_SLVERR 2'b10
`define FIFO_DEPTH 8
`define FIFO_WIDTH 32
`endif

/* File: design/align_fifo.v */
// the event fifo module sits with the alignment core, which holds all design logic

/* File: design/stream_delay_advance_align.v */
// per-stream channel delay, bit delay and output advance alignment core
`timescale 1ns/1ps
`include "stream_align_map.vh"
// Contract
// - 8-bit local channel delay per stream
// - local delay limited by stream rate
// - unsigned channel count before storing data
// - 5-bit local bit delay per stream
// - sampling delayed by field quarter bits
// - 9-bit backplane channel delay per stream
// - backplane delay limited by stream rate
// - fast mode uses only streams 0-15
// - 5-bit backplane bit delay per stream
// - backplane bit 0 after bit delay
// - local advance 0,2,4,6 clocks
// - backplane advance 0,2,4,6 at normal rates
// - backplane advance 0,1,2,3 at 32 Mb/s
// - zero advance keeps normal alignment
// - fast mode overrides backplane rate settings
// - 2-bit rate select sets delay range
module stream_delay_advance_align (
    input wire CORE_CLK,
    input wire RSTN,
    input wire FRAME_PULSE,
    input wire [31:0] S_AXI_AWADDR,
    input wire S_AXI_AWVALID,
    output wire S_AXI_AWREADY,
    input wire [31:0] S_AXI_WDATA,
    input wire [3:0] S_AXI_WSTRB,
    input wire S_AXI_WVALID,
    output wire S_AXI_WREADY,
    output reg [1:0] S_AXI_BRESP,
    output reg S_AXI_BVALID,
    input wire S_AXI_BREADY,
    input wire [31:0] S_AXI_ARADDR,
    input wire S_AXI_ARVALID,
    output wire S_AXI_ARREADY,
    output reg [31:0] S_AXI_RDATA,
    output reg [1:0] S_AXI_RRESP,
    output reg S_AXI_RVALID,
    input wire S_AXI_RREADY,
    output wire [31:0] ALIGN_EVT_DATA,
    output wire ALIGN_EVT_VALID,
    input wire ALIGN_EVT_READY,
    output wire EVT_STALL
);
    // ------------------------------------------------------------
    // reset release and frame pulse synchroniser
    // ------------------------------------------------------------
    reg rst_s1;
    reg rst_n;
    always @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            rst_s1 <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_n <= rst_s1;
        end
    end
    reg fp_s1;
    reg fp_s2;
    reg fp_s3;
    reg fp_level;
    wire frame_start;
    always @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            fp_s1 <= 1'b0;
            fp_s2 <= 1'b0;
            fp_s3 <= 1'b0;
            fp_level <= 1'b0;
        end else begin
            fp_s1 <= FRAME_PULSE;
            fp_s2 <= fp_s1;
            fp_s3 <= fp_s2;
            if (fp_s2 == fp_s3) begin
                fp_level <= fp_s3;
            end
        end
    end
    // rising edge of the filtered level opens a frame
    assign frame_start = fp_s2 && fp_s3 && !fp_level;
    // ------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------
    reg [`W_LCD-1:0] local_chan_delay_field [0:31];
    reg [`W_BITDLY-1:0] lbd [0:31];
    reg [`W_BCD-1:0] bcd [0:31];
    reg [`W_BITDLY-1:0] bbd [0:31];
    reg [`W_ADV-1:0] local_out_adv_field [0:31];
    reg [`W_ADV-1:0] bp_out_adv_field [0:31];
    reg [`W_RATE-1:0] lrate [0:31];
    reg [`W_RATE-1:0] brate [0:31];
    reg bp_fast_rate_mode;
    // log2 of the channel count at the given rate code, 32 << code (2 Mb/s slowest)
    function [3:0] rate_chans_log;
        input [1:0] code;
        begin
            rate_chans_log = 4'h5 + {2'b00, code};
        end
    endfunction
    // channel-delay ceiling for a rate: 32 << code, minus one
    function [8:0] delay_cap;
        input [2:0] code;
        begin
            delay_cap = (9'h020 << code) - 9'h001;
        end
    endfunction
    // advance in system clocks; fast mode halves the step
    function [2:0] adv_cycles;
        input [1:0] code;
        input fast;
        begin
            if (fast) begin
                adv_cycles = {1'b0, code};
            end else begin
                adv_cycles = {code, 1'b0};
            end
        end
    endfunction
    // ------------------------------------------------------------
    // axi4-lite slave: one outstanding write and read
    // ------------------------------------------------------------
    reg aw_held;
    reg w_held;
    reg [8:0] aw_idx;
    reg [15:0] w_data;
    reg w_lo_en;
    reg w_hi_en;
    wire wr_go;
    assign S_AXI_AWREADY = !aw_held && !S_AXI_BVALID;
    assign S_AXI_WREADY = !w_held && !S_AXI_BVALID;
    assign wr_go = aw_held && w_held && !S_AXI_BVALID;
    assign S_AXI_ARREADY = !S_AXI_RVALID;
    wire [8:0] wsub;
    wire [4:0] wn;
    assign wsub = aw_idx;
    assign wn = aw_idx[4:0] - 5'h03;
    wire [8:0] wbase;
    assign wbase = aw_idx - {4'h0, wn};
    wire wr_hit;
    assign wr_hit = (wbase == `IDX_LOCAL_CHAN_DELAY) || (wbase == `IDX_LOCAL_BIT_DELAY)
        || (wbase == `IDX_BP_CHAN_DELAY) || (wbase == `IDX_BP_BIT_DELAY)
        || (wbase == `IDX_LOCAL_OUT_ADV) || (wbase == `IDX_BP_OUT_ADV)
        || (wsub == `IDX_CTRL) || (wsub - `IDX_LOCAL_RATE < 9'd32)
        || (wsub - `IDX_BP_RATE < 9'd32);
    integer i;
    always @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_idx <= 9'h000;
            w_data <= `FIELD_RESET;
            w_lo_en <= 1'b0;
            w_hi_en <= 1'b0;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= `AXI_OKAY;
            bp_fast_rate_mode <= 1'b0;
            for (i = 0; i < 32; i = i + 1) begin
                local_chan_delay_field[i] <= 8'h00;
                lbd[i] <= 5'h00;
                bcd[i] <= 9'h000;
                bbd[i] <= 5'h00;
                local_out_adv_field[i] <= 2'h0;
                bp_out_adv_field[i] <= 2'h0;
                lrate[i] <= 2'h0;
                brate[i] <= 2'h0;
            end
        end else begin
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_held <= 1'b1;
                aw_idx <= S_AXI_AWADDR[10:2];
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_held <= 1'b1;
                w_data <= S_AXI_WDATA[15:0];
                w_lo_en <= S_AXI_WSTRB[0];
                w_hi_en <= S_AXI_WSTRB[1];
            end
            if (S_AXI_BVALID && S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
            end
            if (wr_go) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP <= wr_hit ? `AXI_OKAY : `AXI_SLVERR;
                // reserved upper bits are dropped
                if (w_lo_en) begin
                    if (wbase == `IDX_LOCAL_CHAN_DELAY) local_chan_delay_field[wn] <= w_data[7:0];
                    if (wbase == `IDX_LOCAL_BIT_DELAY) lbd[wn] <= w_data[4:0];
                    if (wbase == `IDX_BP_CHAN_DELAY) bcd[wn][7:0] <= w_data[7:0];
                    if (wbase == `IDX_BP_BIT_DELAY) bbd[wn] <= w_data[4:0];
                    if (wbase == `IDX_LOCAL_OUT_ADV) local_out_adv_field[wn] <= w_data[1:0];
                    if (wbase == `IDX_BP_OUT_ADV) bp_out_adv_field[wn] <= w_data[1:0];
                    if (wsub == `IDX_CTRL) bp_fast_rate_mode <= w_data[`CTRL_FAST_BIT];
                    if (wsub - `IDX_LOCAL_RATE < 9'd32) begin
                        lrate[wsub[4:0] - 5'h0d] <= w_data[1:0];
                    end
                    if (wsub - `IDX_BP_RATE < 9'd32) begin
                        brate[wsub[4:0] - 5'h0d] <= w_data[1:0];
                    end
                end
                if (w_hi_en && wbase == `IDX_BP_CHAN_DELAY) begin
                    bcd[wn][8] <= w_data[8];
                end
            end
        end
    end
    // read path; reserved bits return zero
    wire [8:0] ridx;
    wire [4:0] rn;
    wire [8:0] rbase;
    assign ridx = S_AXI_ARADDR[10:2];
    assign rn = ridx[4:0] - 5'h03;
    assign rbase = ridx - {4'h0, rn};
    always @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= 32'h0000_0000;
            S_AXI_RRESP <= `AXI_OKAY;
        end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            S_AXI_RVALID <= 1'b1;
            S_AXI_RRESP <= `AXI_OKAY;
            S_AXI_RDATA <= 32'h0000_0000;
            if (rbase == `IDX_LOCAL_CHAN_DELAY) S_AXI_RDATA[7:0] <= local_chan_delay_field[rn];
            else if (rbase == `IDX_LOCAL_BIT_DELAY) S_AXI_RDATA[4:0] <= lbd[rn];
            else if (rbase == `IDX_BP_CHAN_DELAY) S_AXI_RDATA[8:0] <= bcd[rn];
            else if (rbase == `IDX_BP_BIT_DELAY) S_AXI_RDATA[4:0] <= bbd[rn];
            else if (rbase == `IDX_LOCAL_OUT_ADV) S_AXI_RDATA[1:0] <= local_out_adv_field[rn];
            else if (rbase == `IDX_BP_OUT_ADV) S_AXI_RDATA[1:0] <= bp_out_adv_field[rn];
            else if (ridx == `IDX_CTRL) S_AXI_RDATA[0] <= bp_fast_rate_mode;
            else if (ridx - `IDX_LOCAL_RATE < 9'd32) begin
                S_AXI_RDATA[1:0] <= lrate[ridx[4:0] - 5'h0d];
            end else if (ridx - `IDX_BP_RATE < 9'd32) begin
                S_AXI_RDATA[1:0] <= brate[ridx[4:0] - 5'h0d];
            end else begin
                S_AXI_RRESP <= `AXI_SLVERR;
            end
        end else if (S_AXI_RVALID && S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
        end
    end
    // ------------------------------------------------------------
    // alignment sequencer: scans streams after each frame start seen in idle; a frame start during a scan is ignored
    // ------------------------------------------------------------
    localparam ST_IDLE = 2'b00;
    localparam ST_SCAN = 2'b01;
    localparam ST_PUSH = 2'b10;
    reg [1:0] state;
    reg [1:0] next_state;
    reg [5:0] scan;
    wire [4:0] sn;
    wire sel_bp;
    assign sn = scan[4:0];
    assign sel_bp = scan[5];
    // effective rate: 4 means 32 Mb/s in fast mode
    reg [2:0] eff_rate;
    reg stream_used;
    reg [8:0] chan_dly;
    reg [4:0] bit_dly;
    reg [2:0] adv;
    reg [14:0] qtick_off;
    wire fifo_in_ready;
    always @* begin
        if (!sel_bp) begin
            eff_rate = {1'b0, lrate[sn]};
            stream_used = 1'b1;
            chan_dly = {1'b0, local_chan_delay_field[sn]};
            bit_dly = lbd[sn];
            adv = adv_cycles(local_out_adv_field[sn], 1'b0);
        end else begin
            if (bp_fast_rate_mode) begin
                eff_rate = 3'h4;
                stream_used = !sn[4];
            end else begin
                eff_rate = {1'b0, brate[sn]};
                stream_used = 1'b1;
            end
            chan_dly = bcd[sn];
            bit_dly = bbd[sn];
            adv = adv_cycles(bp_out_adv_field[sn], bp_fast_rate_mode);
        end
        if (chan_dly > delay_cap(eff_rate)) begin
            chan_dly = delay_cap(eff_rate);
        end
        // sample point in quarter-bit ticks from the frame boundary
        qtick_off = {1'b0, chan_dly, 5'h00} + {10'h000, bit_dly};
    end
    always @* begin
        case (state)
            ST_IDLE: next_state = frame_start ? ST_SCAN : ST_IDLE;
            ST_SCAN: next_state = ST_PUSH;
            ST_PUSH: begin
                if (!fifo_in_ready) begin
                    next_state = ST_PUSH;
                end else if (scan == 6'h3f) begin
                    next_state = ST_IDLE;
                end else begin
                    next_state = ST_SCAN;
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end
    reg [31:0] evt_word;
    always @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            scan <= 6'h00;
            evt_word <= 32'h0000_0000;
        end else begin
            state <= next_state;
            if (state == ST_IDLE) begin
                scan <= 6'h00;
            end else if (state == ST_PUSH && fifo_in_ready) begin
                scan <= scan + 6'h01;
            end
            if (state == ST_SCAN) begin
                evt_word <= {stream_used, sel_bp, sn, eff_rate, adv, 4'h0, qtick_off};
            end
        end
    end
    // stalled sequencer holds the stream until the fifo has a free slot
    assign EVT_STALL = (state == ST_PUSH) && !fifo_in_ready;
    align_fifo #(
        .WIDTH(`FIFO_WIDTH),
        .DEPTH(`FIFO_DEPTH),
        .AW(3)
    ) u_fifo (
        .clk(CORE_CLK),
        .rst_n(rst_n),
        .in_data(evt_word),
        .in_valid(state == ST_PUSH),
        .in_ready(fifo_in_ready),
        .out_data(ALIGN_EVT_DATA),
        .out_valid(ALIGN_EVT_VALID),
        .out_ready(ALIGN_EVT_READY)
    );
endmodule
// ------------------------------------------------------------
// event fifo, parameterised in width and depth
// ------------------------------------------------------------
module align_fifo #(
    parameter WIDTH = 32,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    input wire clk,
    input wire rst_n,
    input wire [WIDTH-1:0] in_data,
    input wire in_valid,
    output wire in_ready,
    output reg [WIDTH-1:0] out_data,
    output wire out_valid,
    input wire out_ready
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0] wr_ptr;
    reg [AW:0] rd_ptr;
    wire full;
    wire empty;
    wire do_wr;
    wire do_rd;
    assign full = (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]) && (wr_ptr[AW] != rd_ptr[AW]);
    assign empty = (wr_ptr == rd_ptr);
    assign in_ready = !full;
    assign out_valid = !empty;
    assign do_wr = in_valid && !full;
    assign do_rd = out_ready && !empty;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= {(AW+1){1'b0}};
            rd_ptr <= {(AW+1){1'b0}};
        end else begin
            if (do_wr) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (do_rd) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end
    always @(posedge clk) begin
        if (do_wr) begin
            mem[wr_ptr[AW-1:0]] <= in_data;
        end
    end
    always @* begin
        out_data = mem[rd_ptr[AW-1:0]];
    end
endmodule

/* File: tb/stream_align_properties.sv */
// port-level checks of the stream alignment block
`timescale 1ns/1ps
module stream_align_properties (
    input wire CORE_CLK,
    input wire RSTN,
    input wire S_AXI_AWREADY,
    input wire S_AXI_BVALID,
    input wire S_AXI_BREADY,
    input wire S_AXI_ARVALID,
    input wire S_AXI_ARREADY,
    input wire [31:0] S_AXI_RDATA,
    input wire [1:0] S_AXI_RRESP,
    input wire S_AXI_RVALID,
    input wire S_AXI_RREADY,
    input wire [31:0] ALIGN_EVT_DATA,
    input wire ALIGN_EVT_VALID,
    input wire ALIGN_EVT_READY,
    input wire EVT_STALL
);
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RSTN);
    AST_RD_ANSWER: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
        else $error("read answer late");
    AST_RD_HOLD: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID
        && $stable(S_AXI_RDATA)) else $error("read answer not held");
    AST_AR_BLOCK: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
        else $error("read taken while answer pending");
    AST_AW_BLOCK: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID
        && !S_AXI_AWREADY) else $error("write answer not held");
    AST_ERR_ZERO: assert property (
        S_AXI_RVALID && S_AXI_RRESP != 2'b00 |-> S_AXI_RRESP == 2'b10 && S_AXI_RDATA == 0)
        else $error("error read with data");
    AST_EVT_HOLD: assert property (ALIGN_EVT_VALID && !ALIGN_EVT_READY |=> ALIGN_EVT_VALID
        && $stable(ALIGN_EVT_DATA)) else $error("event word not held");
    AST_LOC_ADV: assert property (
        ALIGN_EVT_VALID && ALIGN_EVT_DATA[31] && !ALIGN_EVT_DATA[30] |-> !ALIGN_EVT_DATA[19])
        else $error("odd local advance");
    AST_LOC_CEIL: assert property (
        ALIGN_EVT_VALID && ALIGN_EVT_DATA[31] && !ALIGN_EVT_DATA[30] |-> !ALIGN_EVT_DATA[24]
        && ALIGN_EVT_DATA[14:5] <= (10'h020 << ALIGN_EVT_DATA[23:22]) - 10'h001)
        else $error("local delay above rate ceiling");
    AST_FAST_ADV: assert property (
        ALIGN_EVT_VALID && ALIGN_EVT_DATA[31:30] == 2'b11 && ALIGN_EVT_DATA[24:22] == 3'h4
        |-> ALIGN_EVT_DATA[21:19] <= 3'h3 && !ALIGN_EVT_DATA[29]) else $error("fast stream bad");
    AST_STALL: assert property (EVT_STALL |-> ALIGN_EVT_VALID)
        else $error("stall with empty buffer");
    cover property (EVT_STALL);
endmodule
bind stream_delay_advance_align stream_align_properties stream_align_properties_i (
    .CORE_CLK(CORE_CLK), .RSTN(RSTN), .S_AXI_AWREADY(S_AXI_AWREADY),
    .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARVALID(S_AXI_ARVALID),
    .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP),
    .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
    .ALIGN_EVT_DATA(ALIGN_EVT_DATA), .ALIGN_EVT_VALID(ALIGN_EVT_VALID),
    .ALIGN_EVT_READY(ALIGN_EVT_READY), .EVT_STALL(EVT_STALL));

/* File: tb/evt_sink.sv */
// consumer of the alignment event stream, with a stall control
`timescale 1ns/1ps
module evt_sink (
    input wire clk,
    input wire [31:0] data,
    input wire valid,
    output logic ready,
    input wire hold
);
    logic [31:0] words [$];
    logic fire = 0;
    logic [31:0] cap = 0;
    initial ready = 0;
    // sampled mid-cycle so a pop never races the buffer update
    always @(negedge clk) begin
        fire = valid && ready;
        cap = data;
    end
    always @(posedge clk) begin
        if (fire) words.push_back(cap);
        ready <= !hold;
    end
endmodule

/* File: tb/stream_delay_advance_align_tb.sv */
// self-checking bench of the stream alignment block
`timescale 1ns/1ps
`include "stream_align_map.vh"
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_mismatch++; \
    $display("ERROR %0t got %h expected %h", $time, (a), (b)); end end
module stream_delay_advance_align_tb;
    logic clk = 0, rstn = 0, frame = 0, hold = 0;
    logic [31:0] awaddr = 0, wdata = 0, araddr = 0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic lag = 0;
    logic [3:0] strb = 4'hf;
    wire awready, wready, bvalid, arready, rvalid, evt_valid, evt_ready, evt_stall;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata, evt_data;
    int n_mismatch = 0, total_checks = 0;
    logic [31:0] w [64];
    stream_delay_advance_align stream_delay_advance_align_i (.CORE_CLK(clk), .RSTN(rstn),
        .FRAME_PULSE(frame), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
        .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(strb),
        .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
        .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
        .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
        .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
        .ALIGN_EVT_DATA(evt_data), .ALIGN_EVT_VALID(evt_valid),
        .ALIGN_EVT_READY(evt_ready), .EVT_STALL(evt_stall));
    evt_sink evt_sink_i (.clk(clk), .data(evt_data), .valid(evt_valid), .ready(evt_ready),
        .hold(hold));
    initial forever #50 clk = ~clk;
    task automatic results();
        begin
            $display("checks %0d mismatches %0d", total_checks, n_mismatch);
            if (n_mismatch == 0 && total_checks > 0) $display("Regression OK");
            else $display("Regression broken");
            $finish;
        end
    endtask
    // ----------------------------------------
    // bus master: readiness sampled mid-cycle, released after the taking edge
    // ----------------------------------------
    task automatic wr(input [8:0] idx, input [31:0] d, input [1:0] er);
        int k;
        logic a, b, fin;
        begin
            fin = 0;
            @(posedge clk);
            awaddr <= {21'h0, idx, 2'b00};
            wdata <= d;
            awvalid <= 1;
            wvalid <= 1;
            bready <= !lag;
            for (k = 0; k < 50 && !fin; k++) begin
                @(negedge clk);
                a = awready;
                b = wready;
                if (bvalid) begin `CHK(bresp, er) fin = 1; end
                @(posedge clk);
                if (a) awvalid <= 0;
                if (b) wvalid <= 0;
                if (fin) bready <= lag;
            end
            // late acceptor: the answer must stand one more edge
            if (fin && lag) begin
                @(posedge clk);
                bready <= 0;
            end
            if (!fin) begin n_mismatch++; results(); end
        end
    endtask
    task automatic rd(input [8:0] idx, input [31:0] ed, input [1:0] er);
        int k;
        logic a, fin;
        begin
            fin = 0;
            @(posedge clk);
            araddr <= {21'h0, idx, 2'b00};
            arvalid <= 1;
            rready <= !lag;
            for (k = 0; k < 50 && !fin; k++) begin
                @(negedge clk);
                a = arready;
                if (rvalid) begin `CHK(rdata, ed) `CHK(rresp, er) fin = 1; end
                @(posedge clk);
                if (a) arvalid <= 0;
                if (fin) rready <= lag;
            end
            if (fin && lag) begin
                @(posedge clk);
                rready <= 0;
            end
            if (!fin) begin n_mismatch++; results(); end
        end
    endtask
    // stalls the sink first so the buffer fills and refuses, then drains it
    task automatic run_frame(input logic stall);
        int k;
        begin
            evt_sink_i.words.delete();
            @(posedge clk);
            hold <= stall;
            frame <= 1;
            repeat (4) @(posedge clk);
            frame <= 0;
            for (k = 0; k < 300 && stall && evt_stall !== 1'b1; k++) @(negedge clk);
            if (stall) begin `CHK(evt_stall, 1'b1) `CHK(evt_valid, 1'b1) end
            @(posedge clk);
            hold <= 0;
            for (k = 0; k < 2000 && evt_sink_i.words.size() < 64; k++) @(posedge clk);
            if (evt_sink_i.words.size() < 64) begin n_mismatch++; results(); end
            for (k = 0; k < 64; k++) w[k] = evt_sink_i.words[k];
            @(negedge clk);
            `CHK(evt_valid, 1'b0)
        end
    endtask
    function automatic [31:0] ew(input bp, input [4:0] n, input [8:0] ch, input [4:0] bd,
        input [1:0] adv, input [1:0] rate, input fast);
        logic [9:0] ceil;
        logic [2:0] er, ea;
        begin
            ceil = (bp && fast) ? 10'h1ff : (10'h020 << rate) - 10'h001;
            er = (bp && fast) ? 3'h4 : {1'b0, rate};
            ea = (bp && fast) ? {1'b0, adv} : {adv, 1'b0};
            if (ch > ceil) ch = ceil[8:0];
            ew = {1'b1, bp, n, er, ea, 4'h0, {1'b0, ch} * 15'h0020 + bd};
        end
    endfunction
    initial begin
        #(100 * 90000);
        n_mismatch++;
        results();
    end
    initial begin
        repeat (12) @(posedge clk);
        rstn <= 1;
        repeat (3) @(posedge clk);
        for (int i = 0; i < 6; i++) rd(9'(3 + i * 32), 0, `AXI_OKAY);
        wr(`IDX_LOCAL_CHAN_DELAY, 32'hffff_ffff, `AXI_OKAY);
        rd(`IDX_LOCAL_CHAN_DELAY, 32'h0000_00ff, `AXI_OKAY);
        wr(`IDX_LOCAL_BIT_DELAY, 32'hffff_fff3, `AXI_OKAY);
        rd(`IDX_LOCAL_BIT_DELAY, 32'h0000_0013, `AXI_OKAY);
        wr(`IDX_BP_CHAN_DELAY, 32'hffff_ffff, `AXI_OKAY);
        rd(`IDX_BP_CHAN_DELAY, 32'h0000_01ff, `AXI_OKAY);
        wr(`IDX_BP_BIT_DELAY, 32'h0000_001f, `AXI_OKAY);
        rd(`IDX_BP_BIT_DELAY, 32'h0000_001f, `AXI_OKAY);
        wr(`IDX_LOCAL_OUT_ADV, 32'hffff_ffff, `AXI_OKAY);
        rd(`IDX_LOCAL_OUT_ADV, 32'h0000_0003, `AXI_OKAY);
        wr(`IDX_BP_OUT_ADV, 32'h0000_0002, `AXI_OKAY);
        wr(`IDX_LOCAL_RATE, 32'h0000_0003, `AXI_OKAY);
        wr(`IDX_BP_RATE, 32'h0000_0003, `AXI_OKAY);
        wr(`IDX_LOCAL_CHAN_DELAY + 9'h001, 32'h0000_00c8, `AXI_OKAY);
        wr(`IDX_LOCAL_OUT_ADV + 9'h001, 32'h0000_0001, `AXI_OKAY);
        wr(`IDX_BP_CHAN_DELAY + 9'h001, 32'h0000_0005, `AXI_OKAY);
        wr(`IDX_BP_BIT_DELAY + 9'h001, 32'h0000_0001, `AXI_OKAY);
        wr(`IDX_BP_RATE + 9'h001, 32'h0000_0001, `AXI_OKAY);
        wr(9'h1ff, 32'h0000_0001, `AXI_SLVERR);
        rd(9'h1ff, 0, `AXI_SLVERR);
        // lane 0 only: bit 8 of the backplane delay must stay clear
        lag = 1;
        strb <= 4'h1;
        wr(`IDX_BP_CHAN_DELAY + 9'h002, 32'h0000_01ff, `AXI_OKAY);
        strb <= 4'hf;
        rd(`IDX_BP_CHAN_DELAY + 9'h002, 32'h0000_00ff, `AXI_OKAY);
        lag = 0;
        run_frame(1);
        `CHK(w[0], ew(0, 0, 255, 19, 3, 3, 0))
        `CHK(w[1], ew(0, 1, 200, 0, 1, 0, 0))
        `CHK(w[2], ew(0, 2, 0, 0, 0, 0, 0))
        `CHK(w[32], ew(1, 0, 511, 31, 2, 3, 0))
        `CHK(w[33], ew(1, 1, 5, 1, 0, 1, 0))
        `CHK(w[52], ew(1, 20, 0, 0, 0, 0, 0))
        wr(`IDX_CTRL, 32'h0000_0001, `AXI_OKAY);
        wr(`IDX_BP_OUT_ADV, 32'h0000_0003, `AXI_OKAY);
        run_frame(0);
        `CHK(w[32], ew(1, 0, 511, 31, 3, 3, 1))
        `CHK(w[33], ew(1, 1, 5, 1, 0, 1, 1))
        `CHK(w[52][31], 1'b0)
        `CHK(w[0], ew(0, 0, 255, 19, 3, 3, 0))
        results();
    end
endmodule
